//--- dcdac_top.sv
// Dual comparator and 8-bit D/A control with AXI4-Lite register slave
//
// How it works
// - Two comparator channels, each with separate control, flags, pins and interrupt.
// - Run enable bit turns each comparator on; off freezes its result.
// - Pin output enable drives the comparison result onto the result pin.
// - Reference select picks external reference pin or the same-numbered D/A.
// - Read-only level monitor shows the current filtered comparison result.
// - Bits 5:4 select no filter, or sampling at f2, f8, f32.
// - Interrupt enable lets the change flag raise the channel interrupt.
// - Change flag sets whenever the comparison result changes.
// - Change flag clears only by reading it as 1, then writing 0.
// - Writing 0 after reading 0 leaves the flag unchanged.
// - Writing 1 to the change flag has no effect.
// - D/A as reference needs its output enable; pin is then not driven.
// - Two 8-bit D/A value registers, output n out of 256 steps.
// - D/A pin driven only with output enable set and reference select clear.
// - D/A output enable removes the pull-up on its port pin.
// - Result pin output can be inverted or not.
// - Filter samples at selected rate, accepts level after two matching samples.
// - Interrupt request is flag and enable, withdrawn when either drops.
// - Interrupt acknowledge leaves the change flag; software clears it.
// - Polarity select bits sit in a separate comparator mode register.
`timescale 1ns/1ps
`default_nettype none

module dcdac_top (
  input wire logic i_core_clk, // 125 MHz peripheral clock
  input wire logic i_rst_b, // Async reset, active low
  // AXI4-Lite write address
  input wire logic i_awvalid, // Write address valid
  output logic o_awready, // Write address ready
  input wire logic [dcdac_pkg::ADDR_W-1:0] i_awaddr, // Write byte address
  input wire logic [2:0] i_awprot, // Unused protection
  // AXI4-Lite write data
  input wire logic i_wvalid, // Write data valid
  output logic o_wready, // Write data ready
  input wire logic [31:0] i_wdata, // Write data
  input wire logic [3:0] i_wstrb, // Byte strobes, lane 0 used
  // AXI4-Lite write response
  output logic o_bvalid, // Write response valid
  input wire logic i_bready, // Write response ready
  output logic [1:0] o_bresp, // Write response
  // AXI4-Lite read address
  input wire logic i_arvalid, // Read address valid
  output logic o_arready, // Read address ready
  input wire logic [dcdac_pkg::ADDR_W-1:0] i_araddr, // Read byte address
  input wire logic [2:0] i_arprot, // Unused protection
  // AXI4-Lite read data
  output logic o_rvalid, // Read data valid
  input wire logic i_rready, // Read data ready
  output logic [31:0] o_rdata, // Read data
  output logic [1:0] o_rresp, // Read response
  // Analog front end
  input wire logic [1:0] i_raw_compare_signal, // Async comparator outputs
  output logic [1:0] o_cmp_run_enable, // Comparator power on
  output logic [1:0] o_ref_source_select, // 1 selects D/A as reference
  output logic [7:0] o_dac_value_0, // D/A 0 code
  output logic [7:0] o_dac_value_1, // D/A 1 code
  output logic [1:0] o_dac_enable, // D/A converter running
  output logic [1:0] o_dac_pin_drive, // D/A result onto its pin
  output logic [1:0] o_dac_pullup_disable, // Remove port pull-up
  // Pins and interrupts
  output logic [1:0] o_cmp_result_pin, // Result pin level
  output logic [1:0] o_cmp_result_pin_oe, // Result pin drive enable
  output logic [1:0] o_cmp_irq // Interrupt request level
);

  logic rst_n, aw_held_r, w_held_r, bvalid_r, rvalid_r, wr_do, wr_lane0, rd_do, rd_hit;
  logic [1:0] rst_sync_r, raw_meta_r, raw_sync_r, samp_prev_r, level_r, level_nxt, level_changed;
  logic [1:0] flag_r, flag_armed_r, dac_oe_r, polarity_r, bresp_r, rresp_r;
  logic [dcdac_pkg::DIV_W-1:0] div_cnt_r;
  logic [dcdac_pkg::ADDR_W-1:0] awaddr_r;
  logic [7:0] ctrl_r [0:1];
  logic [7:0] dac_val_r [0:1];
  logic [7:0] rd_byte;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [9:0] wr_idx, rd_idx;

  function automatic logic [9:0] reg_index(input logic [dcdac_pkg::ADDR_W-1:0] addr);
    reg_index = addr[dcdac_pkg::ADDR_W-1:2];
  endfunction

  function automatic logic reg_mapped(input logic [9:0] idx);
    reg_mapped = (idx == dcdac_pkg::IDX_CMP0_CONTROL) || (idx == dcdac_pkg::IDX_CMP1_CONTROL) ||
                 (idx == dcdac_pkg::IDX_DAC0_VALUE) || (idx == dcdac_pkg::IDX_DAC1_VALUE) ||
                 (idx == dcdac_pkg::IDX_DAC_CONTROL) || (idx == dcdac_pkg::IDX_CMP_MODE);
  endfunction

  function automatic logic filter_strobe(input logic [1:0] sel, input logic [dcdac_pkg::DIV_W-1:0] cnt);
    logic [dcdac_pkg::DIV_W-1:0] mask;
    mask = dcdac_pkg::DIV_MASK_F32;
    case (sel)
      dcdac_pkg::FLT_F2: mask = dcdac_pkg::DIV_MASK_F2;
      dcdac_pkg::FLT_F8: mask = dcdac_pkg::DIV_MASK_F8;
      default: mask = dcdac_pkg::DIV_MASK_F32;
    endcase
    filter_strobe = ((cnt & mask) == mask);
  endfunction

  // Reset release through two flops
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Comparator outputs are asynchronous to the bus clock
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_meta_r <= 2'h0;
      raw_sync_r <= 2'h0;
    end else begin
      raw_meta_r <= i_raw_compare_signal;
      raw_sync_r <= raw_meta_r;
    end
  end

  // Shared divider gives the f2, f8 and f32 sampling taps
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + 5'h01;
    end
  end

  // Per-channel filter and change detection
  always_comb begin
    level_nxt = level_r;
    level_changed = 2'h0;
    for (int ch = 0; ch < 2; ch++) begin
      if (ctrl_r[ch][dcdac_pkg::BIT_RUN_ENABLE]) begin
        if (ctrl_r[ch][dcdac_pkg::BIT_FILTER_SELECT_HI:dcdac_pkg::BIT_FILTER_SELECT_LO] == dcdac_pkg::FLT_NONE) begin
          level_nxt[ch] = raw_sync_r[ch];
        end else if (filter_strobe(ctrl_r[ch][dcdac_pkg::BIT_FILTER_SELECT_HI:dcdac_pkg::BIT_FILTER_SELECT_LO],
                                   div_cnt_r) && (raw_sync_r[ch] == samp_prev_r[ch])) begin
          level_nxt[ch] = raw_sync_r[ch];
        end
      end
      level_changed[ch] = (level_nxt[ch] != level_r[ch]);
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_prev_r <= {dcdac_pkg::RST_LEVEL, dcdac_pkg::RST_LEVEL};
      level_r <= {dcdac_pkg::RST_LEVEL, dcdac_pkg::RST_LEVEL};
    end else begin
      level_r <= level_nxt;
      for (int ch = 0; ch < 2; ch++) begin
        // Sample history only advances on the chosen tap
        if (filter_strobe(ctrl_r[ch][dcdac_pkg::BIT_FILTER_SELECT_HI:dcdac_pkg::BIT_FILTER_SELECT_LO], div_cnt_r)) begin
          samp_prev_r[ch] <= raw_sync_r[ch];
        end
      end
    end
  end

  // AXI4-Lite write channel handshakes
  assign o_awready = !aw_held_r && !bvalid_r;
  assign o_wready = !w_held_r && !bvalid_r;
  assign wr_do = aw_held_r && w_held_r && !bvalid_r;
  assign wr_idx = reg_index(awaddr_r);
  assign wr_lane0 = wr_do && wstrb_r[0] && reg_mapped(wr_idx);

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= i_awaddr;
      end else if (wr_do) begin
        aw_held_r <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= i_wdata;
        wstrb_r <= i_wstrb;
      end else if (wr_do) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= dcdac_pkg::RESP_OKAY;
    end else begin
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r <= reg_mapped(wr_idx) ? dcdac_pkg::RESP_OKAY : dcdac_pkg::RESP_SLVERR;
      end else if (i_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel; one read outstanding
  assign o_arready = !rvalid_r;
  assign rd_do = i_arvalid && o_arready;
  assign rd_idx = reg_index(i_araddr);
  assign rd_hit = reg_mapped(rd_idx);

  always_comb begin
    rd_byte = 8'h00;
    case (rd_idx)
      dcdac_pkg::IDX_CMP0_CONTROL: rd_byte = {flag_r[0], ctrl_r[0][6:4], level_r[0], ctrl_r[0][2:0]};
      dcdac_pkg::IDX_CMP1_CONTROL: rd_byte = {flag_r[1], ctrl_r[1][6:4], level_r[1], ctrl_r[1][2:0]};
      dcdac_pkg::IDX_DAC0_VALUE: rd_byte = dac_val_r[0];
      dcdac_pkg::IDX_DAC1_VALUE: rd_byte = dac_val_r[1];
      dcdac_pkg::IDX_DAC_CONTROL: rd_byte = {6'h00, dac_oe_r};
      dcdac_pkg::IDX_CMP_MODE: rd_byte = {6'h00, polarity_r};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= dcdac_pkg::RESP_OKAY;
    end else begin
      if (rd_do) begin
        rvalid_r <= 1'b1;
        rdata_r <= {24'h000000, rd_byte};
        rresp_r <= rd_hit ? dcdac_pkg::RESP_OKAY : dcdac_pkg::RESP_SLVERR;
      end else if (i_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Comparator control bits; level monitor and flag handled apart
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r[0] <= dcdac_pkg::RST_CMP_CONTROL;
      ctrl_r[1] <= dcdac_pkg::RST_CMP_CONTROL;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (wr_lane0 && (wr_idx == (dcdac_pkg::IDX_CMP0_CONTROL + 10'(ch)))) begin
          ctrl_r[ch] <= {1'b0, wdata_r[6:4], 1'b0, wdata_r[2:0]};
        end
      end
    end
  end

  // Clear needs a prior read of 1; a read of 0 disarms, so a late set survives
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_armed_r <= 2'h0;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (rd_do && (rd_idx == (dcdac_pkg::IDX_CMP0_CONTROL + 10'(ch)))) begin
          flag_armed_r[ch] <= flag_r[ch];
        end else if (wr_lane0 && (wr_idx == (dcdac_pkg::IDX_CMP0_CONTROL + 10'(ch)))) begin
          flag_armed_r[ch] <= 1'b0;
        end
      end
    end
  end

  // Set beats clear in the same cycle; interrupt acknowledge has no path here
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 2'h0;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (level_changed[ch]) begin
          flag_r[ch] <= 1'b1;
        end else if (wr_lane0 && (wr_idx == (dcdac_pkg::IDX_CMP0_CONTROL + 10'(ch))) &&
                     !wdata_r[dcdac_pkg::BIT_CHANGE_FLAG] && flag_armed_r[ch]) begin
          flag_r[ch] <= 1'b0;
        end
      end
    end
  end

  // D/A value and control registers
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_val_r[0] <= dcdac_pkg::RST_DAC_VALUE;
      dac_val_r[1] <= dcdac_pkg::RST_DAC_VALUE;
      dac_oe_r <= dcdac_pkg::RST_DAC_CONTROL;
    end else begin
      if (wr_lane0 && (wr_idx == dcdac_pkg::IDX_DAC0_VALUE)) begin
        dac_val_r[0] <= wdata_r[7:0];
      end
      if (wr_lane0 && (wr_idx == dcdac_pkg::IDX_DAC1_VALUE)) begin
        dac_val_r[1] <= wdata_r[7:0];
      end
      if (wr_lane0 && (wr_idx == dcdac_pkg::IDX_DAC_CONTROL)) begin
        dac_oe_r <= wdata_r[dcdac_pkg::BIT_DAC_OUTPUT_ENABLE+1:dcdac_pkg::BIT_DAC_OUTPUT_ENABLE];
      end
    end
  end

  // Comparator mode register holds the result pin polarity
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      polarity_r <= dcdac_pkg::RST_CMP_MODE;
    end else if (wr_lane0 && (wr_idx == dcdac_pkg::IDX_CMP_MODE)) begin
      polarity_r <= wdata_r[dcdac_pkg::BIT_RESULT_POLARITY_SELECT+1:dcdac_pkg::BIT_RESULT_POLARITY_SELECT];
    end
  end

  // Pin and analog controls, registered so pins never glitch
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_cmp_result_pin <= 2'h0;
      o_cmp_result_pin_oe <= 2'h0;
      o_dac_pin_drive <= 2'h0;
      o_dac_pullup_disable <= 2'h0;
      o_cmp_run_enable <= 2'h0;
      o_ref_source_select <= 2'h0;
      o_dac_enable <= 2'h0;
      o_dac_value_0 <= dcdac_pkg::RST_DAC_VALUE;
      o_dac_value_1 <= dcdac_pkg::RST_DAC_VALUE;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        o_cmp_result_pin_oe[ch] <= ctrl_r[ch][dcdac_pkg::BIT_PIN_OUT_ENABLE];
        // Low while not enabled so the pin shows no stale level
        o_cmp_result_pin[ch] <= ctrl_r[ch][dcdac_pkg::BIT_PIN_OUT_ENABLE] &
                                (level_r[ch] ^ polarity_r[ch]);
        o_ref_source_select[ch] <= ctrl_r[ch][dcdac_pkg::BIT_REF_SOURCE_SELECT];
        o_cmp_run_enable[ch] <= ctrl_r[ch][dcdac_pkg::BIT_RUN_ENABLE];
        o_dac_pin_drive[ch] <= dac_oe_r[ch] & ~ctrl_r[ch][dcdac_pkg::BIT_REF_SOURCE_SELECT];
      end
      o_dac_enable <= dac_oe_r;
      o_dac_pullup_disable <= dac_oe_r;
      o_dac_value_0 <= dac_val_r[0];
      o_dac_value_1 <= dac_val_r[1];
    end
  end

  // Request is a live level, never latched
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_cmp_irq <= 2'h0;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        o_cmp_irq[ch] <= flag_r[ch] & ctrl_r[ch][dcdac_pkg::BIT_IRQ_ENABLE];
      end
    end
  end

  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;

endmodule

`default_nettype wire

//--- dcdac_pkg.sv
// Constants for the dual comparator and D/A control block
`default_nettype none
package dcdac_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CMP0_CONTROL = 10'h174;
  localparam logic [9:0] IDX_CMP1_CONTROL = 10'h175;
  localparam logic [9:0] IDX_DAC0_VALUE = 10'h178;
  localparam logic [9:0] IDX_DAC1_VALUE = 10'h179;
  localparam logic [9:0] IDX_DAC_CONTROL = 10'h17a;
  localparam logic [9:0] IDX_CMP_MODE = 10'h17b;
  localparam int ADDR_W = 12;

  // Comparator control fields
  localparam int BIT_RUN_ENABLE = 0;
  localparam int BIT_PIN_OUT_ENABLE = 1;
  localparam int BIT_REF_SOURCE_SELECT = 2;
  localparam int BIT_LEVEL_MONITOR = 3;
  localparam int BIT_FILTER_SELECT_LO = 4;
  localparam int BIT_FILTER_SELECT_HI = 5;
  localparam int BIT_IRQ_ENABLE = 6;
  localparam int BIT_CHANGE_FLAG = 7;

  // D/A control and comparator mode fields, bit n for channel n
  localparam int BIT_DAC_OUTPUT_ENABLE = 0;
  localparam int BIT_RESULT_POLARITY_SELECT = 0;

  // Reset values
  localparam logic [7:0] RST_CMP_CONTROL = 8'h08;
  localparam logic RST_LEVEL = 1'b1;
  localparam logic [7:0] RST_DAC_VALUE = 8'h00;
  localparam logic [1:0] RST_DAC_CONTROL = 2'h0;
  localparam logic [1:0] RST_CMP_MODE = 2'h0;

  // Filter select encodings
  localparam logic [1:0] FLT_NONE = 2'h0;
  localparam logic [1:0] FLT_F2 = 2'h1;
  localparam logic [1:0] FLT_F8 = 2'h2;
  localparam logic [1:0] FLT_F32 = 2'h3;

  // Sampling divider masks, strobe when all masked bits are set
  localparam int DIV_W = 5;
  localparam logic [4:0] DIV_MASK_F2 = 5'h01;
  localparam logic [4:0] DIV_MASK_F8 = 5'h07;
  localparam logic [4:0] DIV_MASK_F32 = 5'h1f;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- dcdac_props.sv
// Port-level assertions for the comparator and D/A control block
`timescale 1ns/1ps
`default_nettype none
module dcdac_props (
  input wire logic i_core_clk, // Clock
  input wire logic i_rst_b, // Reset, active low
  input wire logic i_awvalid, // Write address valid
  input wire logic o_awready, // Write address ready
  input wire logic i_wvalid, // Write data valid
  input wire logic o_wready, // Write data ready
  input wire logic o_bvalid, // Write response valid
  input wire logic i_bready, // Write response ready
  input wire logic [1:0] o_bresp, // Write response
  input wire logic i_arvalid, // Read address valid
  input wire logic o_arready, // Read address ready
  input wire logic o_rvalid, // Read data valid
  input wire logic i_rready, // Read data ready
  input wire logic [31:0] o_rdata, // Read data
  input wire logic [1:0] o_ref_source_select, // Reference select
  input wire logic [1:0] o_dac_enable, // D/A running
  input wire logic [1:0] o_dac_pin_drive, // D/A pin drive
  input wire logic [1:0] o_dac_pullup_disable, // Pull-up removal
  input wire logic [1:0] o_cmp_result_pin, // Result pins
  input wire logic [1:0] o_cmp_result_pin_oe // Result pin enables
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  a_bresp_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response withdrawn early");
  a_rdata_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data withdrawn early");
  a_rdata_byte_only: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
    else $error("read data above byte lane");
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
    else $error("write response late");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read response late");
  a_one_write: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while response pending");
  a_result_pin_gate: assert property ((o_cmp_result_pin & ~o_cmp_result_pin_oe) == 2'h0)
    else $error("result pin driven while disabled");
  a_dac_pin_gate: assert property ($stable(o_dac_enable) && $stable(o_ref_source_select)
    |-> o_dac_pin_drive == (o_dac_enable & ~o_ref_source_select))
    else $error("D/A pin drive wrong");
  a_pullup_follow: assert property (o_dac_pullup_disable == o_dac_enable)
    else $error("pull-up removal not tied to D/A enable");
endmodule
bind dcdac_top dcdac_props u_props (.i_core_clk, .i_rst_b, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
  .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .o_rvalid, .i_rready, .o_rdata, .o_ref_source_select,
  .o_dac_enable, .o_dac_pin_drive, .o_dac_pullup_disable, .o_cmp_result_pin, .o_cmp_result_pin_oe);
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the comparator and D/A control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [9:0] C0 = dcdac_pkg::IDX_CMP0_CONTROL;
  localparam logic [9:0] C1 = dcdac_pkg::IDX_CMP1_CONTROL;
  localparam logic [9:0] D0 = dcdac_pkg::IDX_DAC0_VALUE;
  localparam logic [9:0] D1 = dcdac_pkg::IDX_DAC1_VALUE;
  localparam logic [9:0] DC = dcdac_pkg::IDX_DAC_CONTROL;
  localparam logic [9:0] MD = dcdac_pkg::IDX_CMP_MODE;
  localparam logic [1:0] OK = dcdac_pkg::RESP_OKAY;
  localparam logic [1:0] ER = dcdac_pkg::RESP_SLVERR;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic [dcdac_pkg::ADDR_W-1:0] i_awaddr = '0, i_araddr = '0;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic [3:0] i_wstrb = 4'h1;
  logic [2:0] i_awprot = 3'h0, i_arprot = 3'h0;
  logic [1:0] i_raw_compare_signal = 2'h3;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp, o_cmp_run_enable, o_ref_source_select, o_dac_enable, o_dac_pin_drive;
  logic [1:0] o_dac_pullup_disable, o_cmp_result_pin, o_cmp_result_pin_oe, o_cmp_irq;
  logic [7:0] o_dac_value_0, o_dac_value_1;
  int errors = 0, comparisons = 0, cycles = 0, n;
  int lo[4] = '{1, 4, 10, 34};
  int hi[4] = '{6, 9, 21, 69};

  dcdac_top dut_u (.i_core_clk, .i_rst_b, .i_awvalid, .o_awready, .i_awaddr, .i_awprot, .i_wvalid, .o_wready,
    .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .i_arprot,
    .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_raw_compare_signal, .o_cmp_run_enable, .o_ref_source_select,
    .o_dac_value_0, .o_dac_value_1, .o_dac_enable, .o_dac_pin_drive, .o_dac_pullup_disable,
    .o_cmp_result_pin, .o_cmp_result_pin_oe, .o_cmp_irq);

  initial begin
    forever #4 i_core_clk = ~i_core_clk;
  end

  task automatic stop_test;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge i_core_clk);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    i_awaddr <= {idx, 2'h0};
    i_wdata <= {24'h0, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    forever begin
      @(posedge i_core_clk);
      if (!ad && o_awready) begin
        ad = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (!wd && o_wready) begin
        wd = 1'b1;
        i_wvalid <= 1'b0;
      end
      if (o_bvalid) begin
        i_bready <= 1'b0;
        chk(o_bresp, er);
        break;
      end
    end
    @(posedge i_core_clk);
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
    logic ad;
    ad = 1'b0;
    i_araddr <= {idx, 2'h0};
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    forever begin
      @(posedge i_core_clk);
      if (!ad && o_arready) begin
        ad = 1'b1;
        i_arvalid <= 1'b0;
      end
      if (o_rvalid) begin
        i_rready <= 1'b0;
        chk(o_rdata, exp);
        chk(o_rresp, er);
        break;
      end
    end
    @(posedge i_core_clk);
  endtask

  initial begin
    tick(20);
    i_rst_b <= 1'b1;
    tick(3);
    rdc(C0, 32'h08, OK);
    rdc(D0, 32'h00, OK);
    rdc(10'h000, 32'h0, ER);
    wr(10'h000, 8'hff, ER);
    wr(C0, 8'h41, OK);
    i_raw_compare_signal[0] <= 1'b0;
    tick(6);
    chk(o_cmp_irq, 2'b01);
    rdc(C0, 32'hc1, OK);
    wr(C0, 8'hc1, OK);
    rdc(C0, 32'hc1, OK);
    wr(C0, 8'h41, OK);
    rdc(C0, 32'h41, OK);
    chk(o_cmp_irq, 2'b00);
    // Flag set between a zero read and the write must survive
    i_raw_compare_signal[0] <= 1'b1;
    tick(6);
    wr(C0, 8'h41, OK);
    rdc(C0, 32'hc9, OK);
    wr(C0, 8'h81, OK);
    tick(2);
    chk(o_cmp_irq, 2'b00);
    rdc(C0, 32'h89, OK);
    wr(C0, 8'h01, OK);
    rdc(C0, 32'h09, OK);
    wr(C0, 8'h00, OK);
    i_raw_compare_signal[0] <= 1'b0;
    tick(6);
    rdc(C0, 32'h08, OK);
    rdc(C1, 32'h08, OK);
    wr(MD, 8'h02, OK);
    for (int f = 0; f < 4; f++) begin
      wr(C1, {2'b00, 2'(f), 4'h3}, OK);
      i_raw_compare_signal[1] <= ~i_raw_compare_signal[1];
      n = 0;
      do begin
        @(posedge i_core_clk);
        n++;
      end while (o_cmp_result_pin[1] === i_raw_compare_signal[1] && n < 100);
      chk(32'(n >= lo[f] && n <= hi[f]), 32'h1);
      chk(o_cmp_irq, 2'b00);
      rdc(C1, {24'h0, 2'b10, 2'(f), i_raw_compare_signal[1], 3'h3}, OK);
    end
    // Port direction lives outside the block; the bench leaves those pins as inputs
    wr(D0, 8'ha5, OK);
    wr(D1, 8'hff, OK);
    i_wstrb <= 4'h0;
    wr(D0, 8'h11, OK);
    i_wstrb <= 4'h1;
    wr(DC, 8'h03, OK);
    tick(2);
    chk(o_dac_value_0, 8'ha5);
    chk(o_dac_value_1, 8'hff);
    chk(o_dac_pin_drive, 2'b11);
    chk(o_dac_pullup_disable, 2'b11);
    wr(C0, 8'h04, OK);
    tick(2);
    chk(o_ref_source_select, 2'b01);
    chk(o_dac_pin_drive, 2'b10);
    chk(o_dac_enable, 2'b11);
    chk(o_cmp_run_enable, 2'b10);
    chk(o_cmp_result_pin_oe, 2'b10);
    chk(o_cmp_result_pin, 2'b00);
    rdc(D0, 32'ha5, OK);
    rdc(DC, 32'h03, OK);
    stop_test;
  end
endmodule
`default_nettype wire
